// ---- core/ldt_pkg.sv ----
// Purpose: Shared constants and types for the displacement transducer readout
// Assumes: 10 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: Positions in thousandths of an inch or tenths of a millimetre
package ldt_pkg;
  localparam int ADDR_W = 8;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WSPD_OFS = 8'h04;
  localparam logic [7:0] OFFS_OFS = 8'h08;
  localparam logic [7:0] ZERO_OFS = 8'h0c;
  localparam logic [7:0] FAULT_OFS = 8'h10;
  localparam logic [7:0] OTYPE_OFS = 8'h14;
  localparam logic [7:0] VPSET_OFS = 8'h18;
  localparam logic [7:0] POS_OFS = 8'h1c;
  localparam logic [7:0] STAT_OFS = 8'h20;
  localparam logic [7:0] MASK_OFS = 8'h24;
  localparam logic [7:0] RAW_OFS = 8'h28;
  // Control and status fields
  localparam int CTRL_PROG = 0;
  localparam int CTRL_MM = 1;
  localparam int CTRL_DIR = 2;
  localparam int ST_NEW = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_REJ = 3;
  localparam int ST_LOST = 4;
  localparam int ST_W = 5;
  // Reset values and accepted ranges
  localparam logic DIR_RST = 1'b1;
  localparam logic MM_RST = 1'b0;
  localparam logic [19:0] WSPD_RST = 20'h7a120;
  localparam logic [19:0] WSPD_VAR_MIN = 20'h7a120;
  localparam logic [19:0] WSPD_VAR_MAX = 20'h927c0;
  localparam logic [19:0] WSPD_UNI_MIN = 20'h01f40;
  localparam logic [19:0] WSPD_UNI_MAX = 20'h02710;
  localparam logic signed [31:0] OFFS_IN_MIN = 32'hfffe7961;
  localparam logic signed [31:0] OFFS_IN_MAX = 32'h000f423f;
  localparam logic signed [31:0] OFFS_MM_MIN = 32'hfffc1fd3;
  localparam logic signed [31:0] OFFS_MM_MAX = 32'h0026c1dd;
  localparam logic [16:0] ZERO_RST_US = 17'h003e8;
  localparam logic [16:0] ZERO_MIN_US = 17'h003e8;
  localparam logic [16:0] ZERO_MAX_US = 17'h1869f;
  localparam logic [6:0] FAULT_RST_US = 7'h0a;
  localparam logic [6:0] FAULT_MAX_US = 7'h63;
  // Output types
  localparam logic [1:0] OT_FIRST = 2'h0;
  localparam logic [1:0] OT_STARTSTOP = 2'h1;
  localparam logic [1:0] OT_PULSE_EXT = 2'h2;
  localparam logic [1:0] OT_PULSE_INT = 2'h3;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLE_NS = 1_000_000_000 / CLK_HZ;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int PING_US = 1;
  localparam int PING_CYC = PING_US * CYC_PER_US;
  localparam int PERIOD_US = 1000;
  localparam int PERIOD_CYC_DEF = PERIOD_US * CYC_PER_US;
  localparam int TIMEOUT_US = 110_000;
  localparam int TIMEOUT_CYC_DEF = TIMEOUT_US * CYC_PER_US;
  localparam int K_INCH = 1000;
  localparam int K_MM = 254;
  localparam int DIV_STEPS = 48;

  typedef struct packed {
    logic prog;
    logic mm;
    logic dir;
    logic [19:0] wspd;
    logic signed [31:0] offs;
    logic [16:0] zero_us;
    logic [6:0] fault_us;
    logic [1:0] otype;
    logic [7:0] vpset;
  } cfg_t;

  localparam cfg_t CFG_RST = '{prog: 1'b0, mm: MM_RST, dir: DIR_RST,
    wspd: WSPD_RST, offs: 32'h0, zero_us: ZERO_RST_US,
    fault_us: FAULT_RST_US, otype: OT_FIRST, vpset: 8'h00};
endpackage

// ---- core/ldt_position_readout.sv ----
// Purpose: Pulse-time readout of a displacement transducer into a position
// Assumes: Pin inputs synchronous to aclk; registers over AXI4-Lite
// Notes: One clock; pulse times are counted in aclk cycles
// Contract
// - Variable-pulse card wire speed 500.000..600.000 us/in scales time.
// - Universal card takes wire speed 8.000..10.000 us/in.
// - Configuration writes are refused outside program mode.
// - Direction 0: position grows as magnet moves away from head.
// - Direction 1: position grows toward head; resets to 1.
// - Offset -99.999..999.999 in; position equals entered value there.
// - Pulse matching zero pulse time is absolute zero; resets 1.000 ms.
// - Zero pulse time accepts 1.000..99.999 ms.
// - Pulse matching fault pulse time raises transducer error.
// - Fault time resets 10 us, accepts 1..99 us, 0 disables.
// - Output type 0..3: first digital, start/stop, pulse ext, pulse int.
// - Unit select: 0 inches, 1 millimetres; resets to inches.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ldt_position_readout
  import ldt_pkg::*;
#(
  parameter int PERIOD_CYC = PERIOD_CYC_DEF,
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic card_universal,
  input wire logic ldt_pulse,
  output logic interrogate,
  output logic irq
);
  typedef enum logic [2:0] {M_IDLE, M_ARM, M_RUN, M_DIV, M_POS} state_t;

  state_t state_reg;
  cfg_t cfg_reg;
  logic card_reg;
  logic pulse_reg;
  logic [23:0] free_reg;
  logic [23:0] per_reg;
  logic [23:0] t0_reg;
  logic [7:0] ping_reg;
  logic interrogate_reg;
  logic [47:0] dvd_reg;
  logic [19:0] rem_reg;
  logic [5:0] cnt_reg;
  logic signed [31:0] raw_reg;
  logic signed [31:0] base_reg;
  logic signed [31:0] pos_reg;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] mask_reg;
  logic irq_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [ADDR_W-1:0] wa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;

  function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      CTRL_OFS: begin
        v[CTRL_PROG] = cfg_reg.prog;
        v[CTRL_MM] = cfg_reg.mm;
        v[CTRL_DIR] = cfg_reg.dir;
      end
      WSPD_OFS: v = {12'h0, cfg_reg.wspd};
      OFFS_OFS: v = cfg_reg.offs;
      ZERO_OFS: v = {15'h0, cfg_reg.zero_us};
      FAULT_OFS: v = {25'h0, cfg_reg.fault_us};
      OTYPE_OFS: v = {30'h0, cfg_reg.otype};
      VPSET_OFS: v = {24'h0, cfg_reg.vpset};
      POS_OFS: v = pos_reg;
      STAT_OFS: v = {27'h0, stat_reg};
      MASK_OFS: v = {27'h0, mask_reg};
      RAW_OFS: v = raw_reg;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == CTRL_OFS || a == WSPD_OFS || a == OFFS_OFS ||
      a == ZERO_OFS || a == FAULT_OFS || a == OTYPE_OFS ||
      a == VPSET_OFS || a == POS_OFS || a == STAT_OFS ||
      a == MASK_OFS || a == RAW_OFS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  logic [31:0] wmask;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : lane
      assign wmask[8*g +: 8] = {8{ws_reg[g]}};
    end
  endgenerate

  logic [31:0] cur_word;
  always_comb cur_word = rd_mux(wa_reg);
  wire [31:0] wd = (cur_word & ~wmask) | (wd_reg & wmask);
  wire signed [31:0] wd_s = wd;
  wire wr_go = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire prog = cfg_reg.prog;
  wire sel_ctrl = wa_reg == CTRL_OFS;
  wire sel_wspd = wa_reg == WSPD_OFS;
  wire sel_offs = wa_reg == OFFS_OFS;
  wire sel_zero = wa_reg == ZERO_OFS;
  wire sel_fault = wa_reg == FAULT_OFS;
  wire sel_otype = wa_reg == OTYPE_OFS;
  wire sel_vpset = wa_reg == VPSET_OFS;
  wire sel_stat = wa_reg == STAT_OFS;
  wire sel_mask = wa_reg == MASK_OFS;
  wire wr_mapped = is_mapped(wa_reg);
  wire [19:0] wd_wspd = wd[19:0];
  wire in_var = wd[31:20] == 12'h0 && wd_wspd >= WSPD_VAR_MIN &&
    wd_wspd <= WSPD_VAR_MAX;
  wire in_uni = wd[31:20] == 12'h0 && wd_wspd >= WSPD_UNI_MIN &&
    wd_wspd <= WSPD_UNI_MAX;
  wire ok_wspd = card_reg ? in_uni : in_var;
  wire ok_offs = cfg_reg.mm ?
    (wd_s >= OFFS_MM_MIN && wd_s <= OFFS_MM_MAX) :
    (wd_s >= OFFS_IN_MIN && wd_s <= OFFS_IN_MAX);
  wire ok_zero = wd[31:17] == 15'h0 && wd[16:0] >= ZERO_MIN_US &&
    wd[16:0] <= ZERO_MAX_US;
  wire ok_fault = wd[31:7] == 25'h0 && wd[6:0] <= FAULT_MAX_US;
  wire ok_otype = card_reg && wd[31:2] == 30'h0;
  wire ctrl_other = wd[CTRL_MM] != cfg_reg.mm || wd[CTRL_DIR] != cfg_reg.dir;
  wire rej = (sel_ctrl & ~prog & ctrl_other) |
    ((sel_wspd | sel_offs | sel_zero | sel_fault | sel_otype | sel_vpset) &
    ~prog) |
    (prog & ((sel_wspd & ~ok_wspd) | (sel_offs & ~ok_offs) |
    (sel_zero & ~ok_zero) | (sel_fault & ~ok_fault) |
    (sel_otype & ~ok_otype)));
  wire wr_ok = wr_go & wr_mapped & ~rej;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement decode
  wire [1:0] eff = card_reg ? cfg_reg.otype : OT_PULSE_INT;
  wire width_mode = eff == OT_PULSE_EXT || eff == OT_PULSE_INT;
  wire rise = ldt_pulse & ~pulse_reg;
  wire fall = ~ldt_pulse & pulse_reg;
  wire [23:0] elapsed = free_reg - t0_reg;
  wire timeout = elapsed >= 24'(TIMEOUT_CYC);
  wire idle = state_reg == M_IDLE;
  wire per_done = per_reg == 24'(PERIOD_CYC - 1);
  wire start_int = idle & per_done & eff != OT_PULSE_EXT;
  wire start_ext = idle & eff == OT_PULSE_EXT & rise;
  wire stop = state_reg == M_RUN & (width_mode ? fall : rise);
  wire [23:0] zlo = 24'(cfg_reg.zero_us) * 24'(CYC_PER_US);
  wire [23:0] flo = 24'(cfg_reg.fault_us) * 24'(CYC_PER_US);
  wire zero_hit = width_mode && elapsed >= zlo &&
    elapsed < zlo + 24'(CYC_PER_US);
  wire fault_hit = width_mode && cfg_reg.fault_us != 7'h0 &&
    elapsed >= flo && elapsed < flo + 24'(CYC_PER_US);
  wire [47:0] kmul = cfg_reg.mm ? 48'(K_MM) : 48'(K_INCH);
  wire [47:0] dividend = 48'(elapsed) * 48'(CYCLE_NS) * kmul;
  wire [20:0] rem_sh = {rem_reg, dvd_reg[47]};
  wire div_ge = rem_sh >= {1'b0, cfg_reg.wspd};
  wire [20:0] rem_sub = rem_sh - {1'b0, cfg_reg.wspd};
  wire signed [31:0] raw_new = dvd_reg[31:0];
  wire signed [31:0] delta = raw_new - base_reg;
  wire signed [31:0] pos_new = cfg_reg.dir ? cfg_reg.offs - delta :
    cfg_reg.offs + delta;
  wire [7:0] ping_len = (eff == OT_PULSE_INT && cfg_reg.vpset != 8'h0) ?
    cfg_reg.vpset : 8'(PING_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  logic [ST_W-1:0] stat_next;
  always_comb begin
    ev = '0;
    ev[ST_NEW] = state_reg == M_POS;
    ev[ST_ZERO] = stop & zero_hit;
    ev[ST_FAULT] = stop & fault_hit & ~zero_hit;
    ev[ST_REJ] = wr_go & wr_mapped & rej;
    ev[ST_LOST] = (state_reg == M_ARM || state_reg == M_RUN) & ~stop &
      timeout;
    clr = (wr_go & sel_stat) ? wd[ST_W-1:0] : '0;
    stat_next = (stat_reg & ~clr) | ev;
  end

  always_ff @(posedge aclk) begin
    card_reg <= card_universal;
    if (!aresetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_reg);
      if (wr_go & sel_mask) begin
        mask_reg <= wd[ST_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CFG_RST;
      base_reg <= '0;
    end else if (wr_ok) begin
      if (sel_ctrl) begin
        cfg_reg.prog <= wd[CTRL_PROG];
        cfg_reg.mm <= wd[CTRL_MM];
        cfg_reg.dir <= wd[CTRL_DIR];
      end
      if (sel_wspd) cfg_reg.wspd <= wd_wspd;
      if (sel_offs) begin
        cfg_reg.offs <= wd_s;
        base_reg <= raw_reg;
      end
      if (sel_zero) cfg_reg.zero_us <= wd[16:0];
      if (sel_fault) cfg_reg.fault_us <= wd[6:0];
      if (sel_otype) cfg_reg.otype <= wd[1:0];
      if (sel_vpset) cfg_reg.vpset <= wd[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrogation and timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_reg <= 1'b0;
      free_reg <= '0;
      per_reg <= '0;
      ping_reg <= '0;
      interrogate_reg <= 1'b0;
    end else begin
      pulse_reg <= ldt_pulse;
      free_reg <= free_reg + 24'h1;
      if (start_int) begin
        per_reg <= '0;
        ping_reg <= ping_len;
        interrogate_reg <= 1'b1;
      end else begin
        if (!per_done) per_reg <= per_reg + 24'h1;
        if (ping_reg != 8'h0) ping_reg <= ping_reg - 8'h1;
        interrogate_reg <= ping_reg > 8'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement state machine and divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= M_IDLE;
      t0_reg <= '0;
      dvd_reg <= '0;
      rem_reg <= '0;
      cnt_reg <= '0;
      raw_reg <= '0;
      pos_reg <= '0;
    end else begin
      unique case (state_reg)
        M_IDLE: begin
          if (start_int) begin
            t0_reg <= free_reg;
            state_reg <= (eff == OT_FIRST) ? M_RUN : M_ARM;
          end else if (start_ext) begin
            t0_reg <= free_reg;
            state_reg <= M_RUN;
          end
        end
        M_ARM: begin
          if (rise) begin
            t0_reg <= free_reg;
            state_reg <= M_RUN;
          end else if (timeout) begin
            state_reg <= M_IDLE;
          end
        end
        M_RUN: begin
          if (stop && zero_hit) begin
            dvd_reg <= '0;
            state_reg <= M_POS;
          end else if (stop && fault_hit) begin
            state_reg <= M_IDLE;
          end else if (stop) begin
            dvd_reg <= dividend;
            rem_reg <= '0;
            cnt_reg <= '0;
            state_reg <= M_DIV;
          end else if (timeout) begin
            state_reg <= M_IDLE;
          end
        end
        M_DIV: begin
          rem_reg <= div_ge ? rem_sub[19:0] : rem_sh[19:0];
          dvd_reg <= {dvd_reg[46:0], div_ge};
          cnt_reg <= cnt_reg + 6'h1;
          if (cnt_reg == 6'(DIV_STEPS - 1)) state_reg <= M_POS;
        end
        M_POS: begin
          raw_reg <= raw_new;
          pos_reg <= pos_new;
          state_reg <= M_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      wa_reg <= '0;
      wd_reg <= '0;
      ws_reg <= '0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= '0;
    end else begin
      if (awvalid && awready_reg) begin
        wa_reg <= awaddr;
        awready_reg <= 1'b0;
      end
      if (wvalid && wready_reg) begin
        wd_reg <= wdata;
        ws_reg <= wstrb;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_mapped && !rej) ? 2'h0 : 2'h2;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
      if (arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux(araddr);
        rresp_reg <= is_mapped(araddr) ? 2'h0 : 2'h2;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign interrogate = interrogate_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// ---- test/ldt_position_readout_monitor.sv ----
// Purpose: Bound checks on the readout ports
// Assumes: Bench keeps vpset at 0 or 10
// Notes: Shadows follow answered writes only
`timescale 1ns/1ps
`default_nettype none
module ldt_position_readout_monitor
  import ldt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic card_universal,
  input wire logic interrogate,
  input wire logic irq
);
  logic [ADDR_W-1:0] a_reg;
  logic [31:0] d_reg;
  logic full_reg;
  logic prog_reg;
  logic mzero_reg;
  logic done;
  logic fw;
  assign done = bvalid && bready && bresp == 2'h0;
  assign fw = bvalid && full_reg;
  ////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (awvalid && awready) begin
      a_reg <= awaddr;
    end
    if (wvalid && wready) begin
      d_reg <= wdata;
      full_reg <= wstrb == 4'hf;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_reg <= 1'b0;
      mzero_reg <= 1'b1;
    end else if (done && a_reg == CTRL_OFS) begin
      prog_reg <= !full_reg || d_reg[CTRL_PROG];
    end else if (done && a_reg == MASK_OFS) begin
      mzero_reg <= full_reg && d_reg[ST_W-1:0] == '0;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_refuse;
    bvalid && a_reg >= WSPD_OFS && a_reg <= VPSET_OFS && !prog_reg
      |-> bresp == 2'h2;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("config write taken outside program mode");
  property p_wspd_var;
    fw && a_reg == WSPD_OFS && !card_universal
      && (d_reg < 32'h7a120 || d_reg > 32'h927c0) |-> bresp == 2'h2;
  endproperty
  a_wspd_var: assert property (p_wspd_var)
    else $error("wire speed outside variable card range taken");
  property p_wspd_uni;
    fw && a_reg == WSPD_OFS && card_universal
      && (d_reg < 32'h1f40 || d_reg > 32'h2710) |-> bresp == 2'h2;
  endproperty
  a_wspd_uni: assert property (p_wspd_uni)
    else $error("wire speed outside universal card range taken");
  property p_zero;
    fw && a_reg == ZERO_OFS && (d_reg < 32'h3e8 || d_reg > 32'h1869f)
      |-> bresp == 2'h2;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero pulse time out of range taken");
  property p_fault;
    fw && a_reg == FAULT_OFS && d_reg > 32'h63 |-> bresp == 2'h2;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault pulse time out of range taken");
  property p_otype;
    bvalid && a_reg == OTYPE_OFS && !card_universal |-> bresp == 2'h2;
  endproperty
  a_otype: assert property (p_otype)
    else $error("output type taken on variable pulse card");
  property p_ping;
    $rose(interrogate) |-> interrogate[*8] ##1 interrogate[*2]
      ##1 !interrogate;
  endproperty
  a_ping: assert property (p_ping)
    else $error("interrogation pulse not ten cycles");
  property p_irq_off;
    mzero_reg[*2] |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with all sources masked");
  c_irq: cover property ($rose(irq));
  c_err: cover property (bvalid && bresp == 2'h2);
  c_uni: cover property ($rose(interrogate) && card_universal);
endmodule
`default_nettype wire

// ---- test/ldt_probe_model.sv ----
// Purpose: Transducer answering each interrogation with one pulse
// Assumes: Pulse width set by the bench in clock cycles
// Notes: Line idles low, as with a pull-down
`timescale 1ns/1ps
`default_nettype none
module ldt_probe_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic interrogate,
  input wire logic [15:0] width,
  output logic ldt_pulse
);
  logic ping_reg;
  logic [15:0] left_reg;
  // Suits first digital and pulse int only; start/stop needs a second pulse, pulse ext gets none
  always_ff @(posedge aclk) begin
    ping_reg <= interrogate;
    if (!aresetn) begin
      left_reg <= '0;
    end else if (interrogate && !ping_reg) begin
      left_reg <= width;
    end else if (left_reg != '0) begin
      left_reg <= left_reg - 16'h1;
    end
  end
  assign ldt_pulse = left_reg != '0;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: Self-checking bench of the transducer readout
// Assumes: Short period 200 and timeout 12000 cycles
// Notes: Widths in cycles; 500 cycles give 0.100 in
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  fail_count++; $display("[ERR] %0t got %h expected %h", $time, \
  (a), (e)); end end
module tb
  import ldt_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, card_universal = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic ldt_pulse, interrogate;
  logic [15:0] width = 16'h1f4;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 aclk = ~aclk;
  ldt_position_readout #(.PERIOD_CYC(200), .TIMEOUT_CYC(12000)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .card_universal(card_universal),
    .ldt_pulse(ldt_pulse), .interrogate(interrogate), .irq(irq));
  ldt_probe_model probe (.aclk(aclk), .aresetn(aresetn),
    .interrogate(interrogate), .width(width), .ldt_pulse(ldt_pulse));
  ////////////////////////////////////////
  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
    logic [1:0] r;
    wr(a, d, r);
    `CHK(r, e)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e)
  endtask
  task automatic poll(input int b);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    for (int n = 0; n < 8000 && d[b] !== 1'b1; n++) rd(STAT_OFS, d, r);
    `CHK(d[b], 1'b1)
  endtask
  task automatic settle(input logic [15:0] w);
    width <= w;
    repeat (2) begin
      wchk(STAT_OFS, 32'h1, 2'h0);
      poll(ST_NEW);
    end
  endtask
  ////////////////////////////////////////
  task automatic reset_values;
    rchk(CTRL_OFS, 32'h4);
    rchk(WSPD_OFS, 32'h7a120);
    rchk(ZERO_OFS, 32'h3e8);
    rchk(FAULT_OFS, 32'h0a);
  endtask
  task automatic refused_writes;
    logic [31:0] d;
    logic [1:0] r;
    wchk(WSPD_OFS, 32'h927c0, 2'h2);
    rchk(WSPD_OFS, 32'h7a120);
    wchk(8'h2c, 32'h0, 2'h2);
    rd(8'h2c, d, r);
    `CHK(r, 2'h2)
    `CHK(d, 32'h0)
    rd(STAT_OFS, d, r);
    `CHK(d[ST_REJ], 1'b1)
    `CHK(irq, 1'b0)
    wchk(MASK_OFS, 32'h8, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wchk(STAT_OFS, 32'h8, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wchk(MASK_OFS, 32'h0, 2'h0);
  endtask
  task automatic range_limits;
    wchk(CTRL_OFS, 32'h5, 2'h0);
    wchk(WSPD_OFS, 32'h7a11f, 2'h2);
    wchk(WSPD_OFS, 32'h927c1, 2'h2);
    wchk(WSPD_OFS, 32'h927c0, 2'h0);
    wchk(WSPD_OFS, 32'h7a120, 2'h0);
    wchk(ZERO_OFS, 32'h3e7, 2'h2);
    wchk(ZERO_OFS, 32'h1869f, 2'h0);
    wchk(ZERO_OFS, 32'h3e8, 2'h0);
    wchk(FAULT_OFS, 32'h64, 2'h2);
    wchk(FAULT_OFS, 32'h0a, 2'h0);
    wchk(OFFS_OFS, 32'hf4240, 2'h2);
    wchk(OFFS_OFS, 32'hfffe7960, 2'h2);
    wchk(OFFS_OFS, 32'hfffe7961, 2'h0);
    wchk(OFFS_OFS, 32'hf423f, 2'h0);
    wchk(OTYPE_OFS, 32'h2, 2'h2);
  endtask
  task automatic position_math;
    settle(16'h1f4);
    rchk(RAW_OFS, 32'h64);
    wchk(OFFS_OFS, 32'h0, 2'h0);
    settle(16'h3e8);
    rchk(POS_OFS, 32'hffffff9c);
    wchk(CTRL_OFS, 32'h1, 2'h0);
    settle(16'h3e8);
    rchk(POS_OFS, 32'h64);
    wchk(OFFS_OFS, 32'h1388, 2'h0);
    settle(16'h3e8);
    rchk(POS_OFS, 32'h1388);
    settle(16'h1f4);
    rchk(POS_OFS, 32'h1324);
  endtask
  task automatic zero_pulse;
    logic [31:0] d;
    logic [1:0] r;
    settle(16'h2715);
    rchk(RAW_OFS, 32'h0);
    rd(STAT_OFS, d, r);
    `CHK(d[ST_ZERO], 1'b1)
  endtask
  task automatic fault_pulse;
    width <= 16'h69;
    wchk(STAT_OFS, 32'h1f, 2'h0);
    poll(ST_FAULT);
    `CHK(irq, 1'b0)
    wchk(MASK_OFS, 32'h4, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    rchk(RAW_OFS, 32'h0);
    settle(16'h1f4);
    wchk(STAT_OFS, 32'h4, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wchk(FAULT_OFS, 32'h0, 2'h0);
    settle(16'h69);
    rchk(RAW_OFS, 32'h15);
  endtask
  task automatic universal_card;
    logic [31:0] v;
    card_universal <= 1'b1;
    repeat (3) @(posedge aclk);
    for (v = 32'h0; v < 32'h4; v++) begin
      wchk(OTYPE_OFS, v, 2'h0);
      rchk(OTYPE_OFS, v);
    end
    wchk(VPSET_OFS, 32'h0a, 2'h0);
    wchk(WSPD_OFS, 32'h2711, 2'h2);
    wchk(WSPD_OFS, 32'h1f3f, 2'h2);
    wchk(WSPD_OFS, 32'h2710, 2'h0);
    rchk(WSPD_OFS, 32'h2710);
    wchk(OTYPE_OFS, 32'h0, 2'h0);
    settle(16'h69);
    rchk(RAW_OFS, 32'h14);
  endtask
  ////////////////////////////////////////
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_values;
    refused_writes;
    range_limits;
    position_math;
    zero_pulse;
    fault_pulse;
    universal_card;
    tally_and_finish;
  end
endmodule
bind ldt_position_readout ldt_position_readout_monitor mon (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
  .wvalid, .wready, .bresp, .bvalid, .bready, .card_universal,
  .interrogate, .irq);
`default_nettype wire
